// ==== inc/sleep_pkg.sv ====
// sleep controller constants: mode codes, delays, peripheral stop-bit positions
// assumes a single 25 MHz clock domain
package sleep_pkg;
  // =======================================================
  // mode selection codes
  localparam logic [2:0] SEL_IDLE = 3'h0;
  localparam logic [2:0] SEL_ADCNR = 3'h1;
  localparam logic [2:0] SEL_PDOWN = 3'h2;
  localparam logic [2:0] SEL_PSAVE = 3'h3;
  localparam logic [2:0] SEL_STBY = 3'h6;
  localparam logic [2:0] SEL_XSTBY = 3'h7;
  // =======================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int STBY_WAKE_CYC = 6;
  localparam int IRQ_HALT_CYC = 4;
  localparam int CNT_W = 16;
  // =======================================================
  // peripheral clock-stop bit positions
  localparam int NPERIPH = 9;
  localparam int PR_ADC = 0;
  localparam int PR_TIM2 = 6;
  localparam logic [8:0] PR_RESET = 9'h000;
  // =======================================================
  // wake source bit positions
  localparam int WK_ADC = 0;
  localparam int WK_TWI_IRQ = 1;
  localparam int WK_TWI_ADDR = 2;
  localparam int WK_T2_OVF = 3;
  localparam int WK_T2_CMP = 4;
  localparam int WK_SPM = 5;
  localparam int WK_LEVEL = 6;
  localparam int WK_EXT = 7;
  localparam int WK_PINCHG = 8;
  localparam int WK_WDT_IRQ = 9;
  localparam int NWAKE = 10;
endpackage : sleep_pkg

// ==== tb/tb_sleep_ctrl.sv ====
// self-checking bench for the sleep-mode controller: mode entry, wake, gating
// assumes sleep_pkg is compiled first; inputs driven at the falling edge
`timescale 1ns/10ps
module tb_sleep_ctrl;
  // =======================================================
  // signals
  logic mclk_in, rstn_in, sleep_enable_bit_in, sleep_instr_in, crystal_clock_in;
  logic [2:0] sleep_mode_select_in;
  logic [15:0] startup_cycles_in;
  logic [9:0] wake_src_in;
  logic reset_wake_in, global_irq_en_in, timer2_enable_in, timer2_async_in;
  logic [1:0] timer2_interrupt_mask_in;
  logic [8:0] peripheral_clock_stop_in, periph_clk_en_out, periph_access_out;
  logic adc_enable_in, comparator_enable_in, comparator_uses_ref_in;
  logic brownout_enable_in, watchdog_enable_in, onchip_debug_fuse_in;
  logic test_port_enable_fuse_in, debug_interface_disable_in;
  logic cpu_clock_domain_en_out, flash_clock_domain_en_out, io_clock_domain_en_out;
  logic converter_clock_domain_en_out, async_clock_en_out, main_osc_en_out;
  logic timer_osc_en_out, timer2_sync_clk_en_out, adc_start_out, adc_extended_out;
  logic adc_power_out, comparator_power_out, vref_enable_out, watchdog_run_out;
  logic brownout_run_out, input_buffer_en_out, debug_active_out, sleeping_out;
  logic wake_irq_out, st;
  logic [7:0] dom;
  int err_total, n_tests;
  // startup delay kept short but above the standby figure so the two differ
  localparam int D_PD = 40;
  localparam int D_SB = sleep_pkg::STBY_WAKE_CYC;
  localparam int HLT = sleep_pkg::IRQ_HALT_CYC;

  assign dom = {cpu_clock_domain_en_out, flash_clock_domain_en_out, io_clock_domain_en_out,
    converter_clock_domain_en_out, async_clock_en_out, main_osc_en_out, timer_osc_en_out,
    input_buffer_en_out};

  sleep_ctrl u_sleep_ctrl (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .sleep_mode_select_in(sleep_mode_select_in),
    .sleep_enable_bit_in(sleep_enable_bit_in), .sleep_instr_in(sleep_instr_in),
    .crystal_clock_in(crystal_clock_in), .startup_cycles_in(startup_cycles_in),
    .wake_src_in(wake_src_in), .reset_wake_in(reset_wake_in),
    .timer2_interrupt_mask_in(timer2_interrupt_mask_in), .global_irq_en_in(global_irq_en_in),
    .timer2_enable_in(timer2_enable_in), .timer2_async_in(timer2_async_in),
    .peripheral_clock_stop_in(peripheral_clock_stop_in), .adc_enable_in(adc_enable_in),
    .comparator_enable_in(comparator_enable_in),
    .comparator_uses_ref_in(comparator_uses_ref_in), .brownout_enable_in(brownout_enable_in),
    .watchdog_enable_in(watchdog_enable_in), .onchip_debug_fuse_in(onchip_debug_fuse_in),
    .test_port_enable_fuse_in(test_port_enable_fuse_in),
    .debug_interface_disable_in(debug_interface_disable_in),
    .cpu_clock_domain_en_out(cpu_clock_domain_en_out),
    .flash_clock_domain_en_out(flash_clock_domain_en_out),
    .io_clock_domain_en_out(io_clock_domain_en_out),
    .converter_clock_domain_en_out(converter_clock_domain_en_out),
    .async_clock_en_out(async_clock_en_out), .main_osc_en_out(main_osc_en_out),
    .timer_osc_en_out(timer_osc_en_out), .timer2_sync_clk_en_out(timer2_sync_clk_en_out),
    .adc_start_out(adc_start_out), .adc_extended_out(adc_extended_out),
    .adc_power_out(adc_power_out), .comparator_power_out(comparator_power_out),
    .vref_enable_out(vref_enable_out), .watchdog_run_out(watchdog_run_out),
    .brownout_run_out(brownout_run_out), .input_buffer_en_out(input_buffer_en_out),
    .debug_active_out(debug_active_out), .sleeping_out(sleeping_out),
    .wake_irq_out(wake_irq_out), .periph_clk_en_out(periph_clk_en_out),
    .periph_access_out(periph_access_out)
  );

  // =======================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // one-cycle sleep pulse; notes any conversion start seen on entry
  task automatic enter(input logic [2:0] mode, input logic en, output logic started);
    started = 1'b0;
    sleep_mode_select_in = mode;
    sleep_enable_bit_in = en;
    sleep_instr_in = 1'b1;
    tick(1);
    if (adc_start_out === 1'b1) started = 1'b1;
    sleep_instr_in = 1'b0;
    sleep_enable_bit_in = 1'b0;
    repeat (3) begin
      tick(1);
      if (adc_start_out === 1'b1) started = 1'b1;
    end
  endtask : enter

  // source held until the cpu clock returns; src below zero means a reset-type wake
  task automatic wake(input int src, input int lo, input int hi, input logic irq);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    if (src < 0) reset_wake_in = 1'b1;
    else wake_src_in[src] = 1'b1;
    while (cpu_clock_domain_en_out !== 1'b1 && n < 200) begin
      tick(1);
      n++;
      if (wake_irq_out === 1'b1) seen = 1'b1;
    end
    if (n == 200) begin
      err_total++;
      report_and_stop();
    end
    tick(1);
    if (wake_irq_out === 1'b1) seen = 1'b1;
    reset_wake_in = 1'b0;
    wake_src_in = 10'h000;
    tick(1);
    chk(n >= lo && n <= hi, 1);
    chk(seen, irq);
  endtask : wake

  // =======================================================
  // clock and main sequence
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  initial begin
    logic [2:0] modes [5];
    int srcs [5];
    int dly [5];
    logic [7:0] edom [5];
    modes = '{sleep_pkg::SEL_ADCNR, sleep_pkg::SEL_PDOWN, sleep_pkg::SEL_PSAVE,
      sleep_pkg::SEL_STBY, sleep_pkg::SEL_XSTBY};
    srcs = '{sleep_pkg::WK_ADC, sleep_pkg::WK_EXT, sleep_pkg::WK_T2_OVF,
      sleep_pkg::WK_PINCHG, sleep_pkg::WK_T2_CMP};
    dly = '{1, D_PD, D_PD, D_SB, D_SB};
    edom = '{8'h1F, 8'h00, 8'h0A, 8'h04, 8'h0E};
    err_total = 0;
    n_tests = 0;
    rstn_in = 1'b0;
    sleep_mode_select_in = 3'h0;
    sleep_enable_bit_in = 1'b0;
    sleep_instr_in = 1'b0;
    crystal_clock_in = 1'b1;
    startup_cycles_in = 16'(D_PD);
    wake_src_in = 10'h000;
    reset_wake_in = 1'b0;
    timer2_interrupt_mask_in = 2'h3;
    global_irq_en_in = 1'b1;
    timer2_enable_in = 1'b1;
    timer2_async_in = 1'b1;
    peripheral_clock_stop_in = 9'h000;
    adc_enable_in = 1'b1;
    comparator_enable_in = 1'b1;
    comparator_uses_ref_in = 1'b0;
    brownout_enable_in = 1'b1;
    watchdog_enable_in = 1'b1;
    onchip_debug_fuse_in = 1'b0;
    test_port_enable_fuse_in = 1'b0;
    debug_interface_disable_in = 1'b0;
    tick(16);
    rstn_in = 1'b1;
    tick(1);
    chk({dom[7:2], dom[0], adc_extended_out, sleeping_out}, 9'h1FE);
    // refused entries: enable bit low, reserved codes, standby codes without crystal
    for (int i = 0; i < 5; i++) begin
      crystal_clock_in = (i < 3);
      enter(i == 0 ? 3'h2 : (i < 3 ? 3'h3 + i[2:0] : 3'h3 + i[2:0]), i != 0, st);
      chk({sleeping_out, cpu_clock_domain_en_out}, 2'h1);
    end
    crystal_clock_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      enter(modes[i], 1'b1, st);
      chk(sleeping_out, 1);
      chk(dom, edom[i]);
      chk(comparator_power_out, i == 0);
      chk({adc_power_out, watchdog_run_out, brownout_run_out, st}, {3'h7, i == 0});
      wake(srcs[i], dly[i] + HLT, dly[i] + HLT + 4, 1'b1);
    end
    chk(adc_extended_out, 0);
    adc_enable_in = 1'b0;
    tick(2);
    adc_enable_in = 1'b1;
    tick(2);
    chk(adc_extended_out, 1);
    // sources outside the mode's list must not wake
    enter(sleep_pkg::SEL_PDOWN, 1'b1, st);
    wake_src_in[sleep_pkg::WK_ADC] = 1'b1;
    tick(20);
    chk(sleeping_out, 1);
    wake_src_in = 10'h000;
    wake(sleep_pkg::WK_LEVEL, D_PD + HLT, D_PD + HLT + 4, 1'b1);
    for (int k = 0; k < 2; k++) begin
      enter(sleep_pkg::SEL_PSAVE, 1'b1, st);
      timer2_interrupt_mask_in = (k == 0) ? 2'h2 : 2'h3;
      global_irq_en_in = (k != 0) ? 1'b0 : 1'b1;
      wake_src_in[sleep_pkg::WK_T2_OVF] = 1'b1;
      tick(20);
      chk(sleeping_out, 1);
      timer2_interrupt_mask_in = 2'h3;
      global_irq_en_in = 1'b1;
      wake(sleep_pkg::WK_T2_OVF, D_PD + HLT, D_PD + HLT + 4, 1'b1);
    end
    // synchronously clocked timer2: sync clock runs, but reaches no other domain
    timer2_async_in = 1'b0;
    enter(sleep_pkg::SEL_PSAVE, 1'b1, st);
    chk({timer_osc_en_out, timer2_sync_clk_en_out, io_clock_domain_en_out}, 3'h2);
    wake(-1, D_PD, D_PD + 4, 1'b0);
    timer2_async_in = 1'b1;
    onchip_debug_fuse_in = 1'b1;
    test_port_enable_fuse_in = 1'b1;
    comparator_uses_ref_in = 1'b1;
    tick(2);
    chk(debug_active_out, 1);
    enter(sleep_pkg::SEL_PDOWN, 1'b1, st);
    chk({main_osc_en_out, comparator_power_out}, 2'h3);
    wake(-1, D_PD, D_PD + 4, 1'b0);
    comparator_uses_ref_in = 1'b0;
    for (int k = 0; k < 3; k++) begin
      onchip_debug_fuse_in = (k != 0);
      test_port_enable_fuse_in = (k != 1);
      debug_interface_disable_in = (k == 2);
      tick(2);
      chk(debug_active_out, 0);
    end
    debug_interface_disable_in = 1'b0;
    adc_enable_in = 1'b0;
    peripheral_clock_stop_in = 9'h041;
    tick(2);
    chk({periph_clk_en_out, periph_access_out}, {~9'h041, ~9'h041});
    peripheral_clock_stop_in = 9'h000;
    tick(2);
    chk({periph_clk_en_out, periph_access_out}, 18'h3FFFF);
    brownout_enable_in = 1'b0;
    adc_enable_in = 1'b0;
    comparator_enable_in = 1'b0;
    tick(2);
    chk(vref_enable_out, 0);
    comparator_enable_in = 1'b1;
    tick(2);
    chk(vref_enable_out, 1);
    report_and_stop();
  end
endmodule : tb_sleep_ctrl

// ==== verilog/periph_gate.sv ====
// per-peripheral clock enable and register access gate
// assumes gating cells downstream; state freezes because enable drops
`timescale 1ns/10ps
module periph_gate #(
  parameter int N = 9
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [N-1:0] stop_in,
  input wire logic io_run_in,
  output logic [N-1:0] clk_en_out,
  output logic [N-1:0] reg_access_out
);
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      clk_en_out <= '0;
      reg_access_out <= '0;
    end else begin
      // clearing a stop bit only re-enables; nothing is reset, so state is kept
      clk_en_out <= ~stop_in & {N{io_run_in}};
      reg_access_out <= ~stop_in;
    end
  end
endmodule : periph_gate

// ==== verilog/sleep_ctrl.sv ====
// sleep-mode controller: mode decode, domain gating, wake qualification
// assumes the cpu pulses sleep_instr_in when it executes a sleep instruction
`timescale 1ns/10ps
module sleep_ctrl #(
  parameter int NP = sleep_pkg::NPERIPH,
  parameter int NW = sleep_pkg::NWAKE
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [2:0] sleep_mode_select_in,
  input wire logic sleep_enable_bit_in,
  input wire logic sleep_instr_in,
  input wire logic crystal_clock_in,
  input wire logic [15:0] startup_cycles_in,
  input wire logic [NW-1:0] wake_src_in,
  input wire logic reset_wake_in,
  input wire logic [1:0] timer2_interrupt_mask_in,
  input wire logic global_irq_en_in,
  input wire logic timer2_enable_in,
  input wire logic timer2_async_in,
  input wire logic [NP-1:0] peripheral_clock_stop_in,
  input wire logic adc_enable_in,
  input wire logic comparator_enable_in,
  input wire logic comparator_uses_ref_in,
  input wire logic brownout_enable_in,
  input wire logic watchdog_enable_in,
  input wire logic onchip_debug_fuse_in,
  input wire logic test_port_enable_fuse_in,
  input wire logic debug_interface_disable_in,
  output logic cpu_clock_domain_en_out,
  output logic flash_clock_domain_en_out,
  output logic io_clock_domain_en_out,
  output logic converter_clock_domain_en_out,
  output logic async_clock_en_out,
  output logic main_osc_en_out,
  output logic timer_osc_en_out,
  output logic timer2_sync_clk_en_out,
  output logic adc_start_out,
  output logic adc_extended_out,
  output logic adc_power_out,
  output logic comparator_power_out,
  output logic vref_enable_out,
  output logic watchdog_run_out,
  output logic brownout_run_out,
  output logic input_buffer_en_out,
  output logic debug_active_out,
  output logic sleeping_out,
  output logic wake_irq_out,
  output logic [NP-1:0] periph_clk_en_out,
  output logic [NP-1:0] periph_access_out
);
  // =======================================================
  // state machine
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE = 4'h4,
    ST_HALT = 4'h8
  } state_e;
  state_e state_r;
  logic [2:0] mode_r;
  logic irq_wake_r;
  logic [2:0] halt_cnt_r;
  logic dly_start;
  logic dly_busy;
  logic dly_done;
  logic [15:0] dly_count;
  logic adc_en_d_r;
  logic adc_ext_r;

  // decode a valid sleep code; standby codes need crystal clock
  function automatic logic valid_mode(input logic [2:0] sel, input logic xtal);
    case (sel)
      sleep_pkg::SEL_IDLE, sleep_pkg::SEL_ADCNR,
      sleep_pkg::SEL_PDOWN, sleep_pkg::SEL_PSAVE: valid_mode = 1'b1;
      sleep_pkg::SEL_STBY, sleep_pkg::SEL_XSTBY: valid_mode = xtal;
      default: valid_mode = 1'b0;
    endcase
  endfunction : valid_mode

  function automatic logic t2_mode(input logic [2:0] m);
    t2_mode = (m == sleep_pkg::SEL_PSAVE) || (m == sleep_pkg::SEL_XSTBY);
  endfunction : t2_mode

  logic sleep_ok;
  assign sleep_ok = sleep_instr_in && sleep_enable_bit_in
                    && valid_mode(sleep_mode_select_in, crystal_clock_in);

  // =======================================================
  // wake qualification per mode
  logic t2_wake;
  logic [NW-1:0] allow;
  logic wake_any;
  assign t2_wake = global_irq_en_in
                   && ((wake_src_in[sleep_pkg::WK_T2_OVF] && timer2_interrupt_mask_in[0])
                   || (wake_src_in[sleep_pkg::WK_T2_CMP] && timer2_interrupt_mask_in[1]));
  always_comb begin
    allow = '0;
    case (mode_r)
      sleep_pkg::SEL_IDLE: allow = '1;
      sleep_pkg::SEL_ADCNR: begin
        allow = '1;
        allow[sleep_pkg::WK_EXT] = 1'b0;
      end
      sleep_pkg::SEL_PDOWN, sleep_pkg::SEL_STBY: begin
        allow[sleep_pkg::WK_TWI_ADDR] = 1'b1;
        allow[sleep_pkg::WK_LEVEL] = 1'b1;
        allow[sleep_pkg::WK_EXT] = 1'b1;
        allow[sleep_pkg::WK_PINCHG] = 1'b1;
        allow[sleep_pkg::WK_WDT_IRQ] = 1'b1;
      end
      sleep_pkg::SEL_PSAVE, sleep_pkg::SEL_XSTBY: begin
        allow[sleep_pkg::WK_TWI_ADDR] = 1'b1;
        allow[sleep_pkg::WK_LEVEL] = 1'b1;
        allow[sleep_pkg::WK_EXT] = 1'b1;
        allow[sleep_pkg::WK_PINCHG] = 1'b1;
        allow[sleep_pkg::WK_WDT_IRQ] = 1'b1;
      end
      default: allow = '0;
    endcase
  end
  logic [NW-1:0] src_eff;
  always_comb begin
    src_eff = wake_src_in;
    src_eff[sleep_pkg::WK_T2_OVF] = 1'b0;
    src_eff[sleep_pkg::WK_T2_CMP] = 1'b0;
  end
  // timer2 sources pass through the mask-qualified term in modes keeping timer2
  assign wake_any = (|(src_eff & allow))
                    || (t2_wake && (t2_mode(mode_r) || mode_r == sleep_pkg::SEL_IDLE
                                    || mode_r == sleep_pkg::SEL_ADCNR));

  // stabilisation delay depends on how deep the clocks went
  always_comb begin
    case (mode_r)
      sleep_pkg::SEL_PDOWN, sleep_pkg::SEL_PSAVE: dly_count = startup_cycles_in;
      sleep_pkg::SEL_STBY, sleep_pkg::SEL_XSTBY:
        dly_count = 16'(sleep_pkg::STBY_WAKE_CYC);
      default: dly_count = 16'h0001;
    endcase
  end
  assign dly_start = (state_r == ST_SLEEP) && (wake_any || reset_wake_in);

  wake_delay #(.W(sleep_pkg::CNT_W)) u_delay (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .start_in(dly_start),
    .count_in(dly_count),
    .busy_out(dly_busy),
    .done_out(dly_done)
  );

  // =======================================================
  // sequencing
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state_r <= ST_RUN;
      mode_r <= sleep_pkg::SEL_IDLE;
      irq_wake_r <= 1'b0;
      halt_cnt_r <= 3'h0;
    end else begin
      case (state_r)
        ST_RUN: if (sleep_ok) begin
          state_r <= ST_SLEEP;
          mode_r <= sleep_mode_select_in;
        end
        ST_SLEEP: if (dly_start) begin
          state_r <= ST_WAKE;
          irq_wake_r <= !reset_wake_in;
        end
        ST_WAKE: if (dly_done) begin
          if (irq_wake_r) begin
            state_r <= ST_HALT;
            halt_cnt_r <= 3'(sleep_pkg::IRQ_HALT_CYC - 1);
          end else begin
            state_r <= ST_RUN;
          end
        end
        ST_HALT: begin
          if (halt_cnt_r == 3'h0) begin
            state_r <= ST_RUN;
          end else begin
            halt_cnt_r <= halt_cnt_r - 3'h1;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // =======================================================
  // clock domain and oscillator enables
  logic asleep;
  logic dbg_on;
  logic deep;
  assign asleep = (state_r != ST_RUN);
  assign dbg_on = onchip_debug_fuse_in && test_port_enable_fuse_in
                  && !debug_interface_disable_in;
  // deep: modes where io and converter clocks are both off
  assign deep = asleep && (mode_r != sleep_pkg::SEL_IDLE) && (mode_r != sleep_pkg::SEL_ADCNR);
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      cpu_clock_domain_en_out <= 1'b1;
      flash_clock_domain_en_out <= 1'b1;
      io_clock_domain_en_out <= 1'b1;
      converter_clock_domain_en_out <= 1'b1;
      async_clock_en_out <= 1'b1;
      main_osc_en_out <= 1'b1;
      timer_osc_en_out <= 1'b1;
      timer2_sync_clk_en_out <= 1'b1;
    end else begin
      cpu_clock_domain_en_out <= !asleep;
      flash_clock_domain_en_out <= !asleep;
      io_clock_domain_en_out <= !asleep || mode_r == sleep_pkg::SEL_IDLE;
      converter_clock_domain_en_out <= !deep;
      async_clock_en_out <= !deep || (t2_mode(mode_r) && timer2_async_in);
      // halted clock must restart once the wake sequence begins
      main_osc_en_out <= !deep || state_r == ST_WAKE || state_r == ST_HALT
                         || mode_r == sleep_pkg::SEL_STBY || mode_r == sleep_pkg::SEL_XSTBY
                         || (t2_mode(mode_r) && timer2_enable_in && !timer2_async_in)
                         || dbg_on;
      timer_osc_en_out <= !deep || (t2_mode(mode_r) && timer2_async_in);
      timer2_sync_clk_en_out <= !asleep || mode_r == sleep_pkg::SEL_IDLE
                                || (t2_mode(mode_r) && timer2_enable_in
                                    && !timer2_async_in);
    end
  end

  // =======================================================
  // analog and support functions
  logic cmp_on;
  assign cmp_on = comparator_enable_in && (!deep || comparator_uses_ref_in);
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      adc_start_out <= 1'b0;
      adc_power_out <= 1'b0;
      comparator_power_out <= 1'b0;
      vref_enable_out <= 1'b0;
      watchdog_run_out <= 1'b0;
      brownout_run_out <= 1'b0;
      input_buffer_en_out <= 1'b1;
      debug_active_out <= 1'b0;
      sleeping_out <= 1'b0;
      wake_irq_out <= 1'b0;
    end else begin
      adc_start_out <= (state_r == ST_RUN) && sleep_ok && adc_enable_in
                       && (sleep_mode_select_in == sleep_pkg::SEL_ADCNR
                           || sleep_mode_select_in == sleep_pkg::SEL_IDLE);
      adc_power_out <= adc_enable_in;
      comparator_power_out <= cmp_on;
      vref_enable_out <= brownout_enable_in || cmp_on || adc_enable_in;
      watchdog_run_out <= watchdog_enable_in;
      brownout_run_out <= brownout_enable_in;
      // wake pins keep their buffers via a separate per-pin path outside
      input_buffer_en_out <= !deep;
      debug_active_out <= dbg_on;
      sleeping_out <= asleep;
      wake_irq_out <= (state_r == ST_HALT) && (halt_cnt_r == 3'h0);
    end
  end

  // re-enable after off forces an extended conversion; cleared by the next start
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      adc_en_d_r <= 1'b0;
      adc_ext_r <= 1'b1;
    end else begin
      adc_en_d_r <= adc_enable_in;
      if (adc_enable_in && !adc_en_d_r) begin
        adc_ext_r <= 1'b1;
      end else if (adc_start_out) begin
        adc_ext_r <= 1'b0;
      end
    end
  end
  assign adc_extended_out = adc_ext_r;

  // =======================================================
  // peripheral clock stopping
  // software is expected to disable a unit before stopping it
  periph_gate #(.N(NP)) u_gate (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .stop_in(peripheral_clock_stop_in),
    .io_run_in(!asleep || mode_r == sleep_pkg::SEL_IDLE),
    .clk_en_out(periph_clk_en_out),
    .reg_access_out(periph_access_out)
  );

  // =======================================================
  // checks
  chk_reserved_nosleep: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_RUN && sleep_instr_in && !valid_mode(sleep_mode_select_in, crystal_clock_in))
    |=> state_r == ST_RUN) else $error("reserved code entered sleep");
  chk_enable_needed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_RUN && !sleep_enable_bit_in) |=> state_r == ST_RUN)
    else $error("sleep without enable bit");
  chk_cpu_stopped: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_SLEEP) |=> !cpu_clock_domain_en_out) else $error("cpu clock ran in sleep");
  chk_adcnr_clocks: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_SLEEP && mode_r == sleep_pkg::SEL_ADCNR) |=>
    converter_clock_domain_en_out && !io_clock_domain_en_out)
    else $error("noise reduction clocks wrong");
  chk_pdown_osc: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_SLEEP && mode_r == sleep_pkg::SEL_PDOWN && !dbg_on
     && $past(state_r) == ST_SLEEP) |=> !main_osc_en_out)
    else $error("oscillator ran in power-down");
  chk_stby_six: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_SLEEP && mode_r == sleep_pkg::SEL_STBY && dly_start) |=>
    (state_r == ST_WAKE)[*6] ##1 state_r != ST_WAKE) else $error("standby wake not six");
  chk_halt_four: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_WAKE && dly_done && irq_wake_r) |=>
    (state_r == ST_HALT)[*4] ##1 state_r == ST_RUN) else $error("halt not four cycles");
  chk_t2_mask: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (state_r == ST_SLEEP && mode_r == sleep_pkg::SEL_PSAVE && !global_irq_en_in
     && !reset_wake_in && !(|(src_eff & allow))) |=> state_r == ST_SLEEP)
    else $error("timer2 woke without enables");
  chk_vref_need: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (!brownout_enable_in && !adc_enable_in && !comparator_enable_in) |=> !vref_enable_out)
    else $error("reference on without user");
  chk_stop_access: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    peripheral_clock_stop_in[0] |=> !periph_access_out[0] && !periph_clk_en_out[0])
    else $error("stopped peripheral still clocked");
  cov_pdown: cover property (@(posedge mclk_in) state_r == ST_SLEEP
    && mode_r == sleep_pkg::SEL_PDOWN ##1 state_r == ST_WAKE);
  cov_adcnr: cover property (@(posedge mclk_in) adc_start_out);
  cov_xstby: cover property (@(posedge mclk_in) state_r == ST_HALT
    && mode_r == sleep_pkg::SEL_XSTBY);
endmodule : sleep_ctrl

// ==== verilog/wake_delay.sv ====
// wake-up delay counter: loads a count on start, flags done during the last count
// assumes start is a one-cycle pulse
`timescale 1ns/10ps
module wake_delay #(
  parameter int W = 16
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [W-1:0] count_in,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] cnt_r;
  // not registered: a registered flag would stretch the wait by one cycle
  assign done_out = busy_out && (cnt_r == W'(1));
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
      busy_out <= 1'b0;
    end else begin
      if (start_in) begin
        cnt_r <= (count_in == '0) ? W'(1) : count_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        cnt_r <= cnt_r - W'(1);
        if (cnt_r == W'(1)) begin
          busy_out <= 1'b0;
        end
      end
    end
  end
endmodule : wake_delay
